// >>> logic/xlr_regs.sv
// Purpose: Command and status register bank of a level-2 link controller
// Assumes: Host bus signals synchronous to clk, one access per strobe
// Notes: Status reads are registered, so data follows the read by one cycle
//
// Overview of operation
// - tx_permit low blocks new I frames; retransmissions always allowed.
// - tx_permit cleared by reset and transmit-channel hard parity error.
// - forced_disconnect holds link down, DM to all, ones idle; reset sets.
// - rx_buffers_available cleared by reset, receive parity error, overrun.
// - active_setup chooses active or passive link set-up; reset clears.
// - password_initiate starts password exchange or waits; reset clears.
// - Host verdict in b6,b5 read with b4; reset clears b6 and b5.
// - disconnected_response_mode 0 answers polls with DM; reset sets.
// - Status 0 bits 0-4 show protocol state code.
// - Status 0 bit 5 high for any connected code other than FRMR and disconnect request.
// - Status 0 bit 6 high when logical link connected (S4 or beyond).
// - A write to status 0 clears bit 7 unless link_reinit coincides, and alters nothing else.
// - Status 1 shows send and receive variables and physical request.
// - Status 2 low bits hold next ack expected; bit 3 reads zero.
// - On next ack update its old value moves into prev_next_ack.
// - acks_done_n low only when all received acks processed.
// - Status 3 holds control field of last error-free frame.
// - Status 4 bits 0-4 hold latest protocol input code.
// - Status 4 bit 5 holds poll/final bit of last good frame.
// - Status 5 to 7 capture three FRMR data bytes.
`timescale 1ns/1ns
module xlr_regs
  import xlr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic wr,
  input wire logic rd,
  input wire logic [XLR_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire xlr_eng_s eng,
  output logic [7:0] rdata,
  output xlr_ctrl_s ctrl,
  output logic new_frame_ok,
  output logic force_dm_all,
  output logic idle_ones,
  output logic answer_per_protocol
);
  xlr_state_s s;
  xlr_state_s next_s;
  logic wr_hit;
  logic rd_hit;

  // Phases S4 and later: every code except the five pre-link ones
  function automatic logic xlr_connected(input logic [4:0] c);
    return !(c == XLR_ST_SUPER || c == XLR_ST_DISC || c == 5'h02 ||
             c == 5'h03 || c == XLR_ST_LINKSETUP);
  endfunction
  function automatic logic xlr_info(input logic [4:0] c);
    return xlr_connected(c) && c != XLR_ST_FRMR && c != XLR_ST_DREQ;
  endfunction

  assign wr_hit = !cs_n && wr;
  assign rd_hit = !cs_n && rd;

  always_comb begin
    next_s = s;
    if (wr_hit && addr == XLR_OFF_CTRL) begin
      next_s.ctrl = xlr_ctrl_s'(wdata);
    end
    // Hardware clear events win over a coincident host write
    if (eng.tx_hpe) begin
      next_s.ctrl.tx_permit = 1'b0;
    end
    if (eng.rx_hpe || eng.rx_overrun) begin
      next_s.ctrl.rx_buffers_available = 1'b0;
    end
    next_s.state_code = eng.state_code;
    next_s.info_transfer_flag = xlr_info(eng.state_code);
    next_s.connected_flag = xlr_connected(eng.state_code);
    if (wr_hit && addr == XLR_OFF_SR0) begin
      next_s.host_buffers_pending_n = 1'b0;
    end
    // Set on link loss wins over the clearing write
    if (eng.link_reinit) begin
      next_s.host_buffers_pending_n = 1'b1;
    end
    next_s.tx_seq_var = eng.tx_seq_var;
    next_s.rx_seq_var = eng.rx_seq_var;
    next_s.phys_request_n = eng.phys_request_n;
    if (eng.next_ack_load) begin
      next_s.next_ack_expected = eng.next_ack_expected;
      next_s.prev_next_ack = s.next_ack_expected;
    end
    next_s.acks_done_n = eng.acks_busy;
    if (eng.rx_frame_ok) begin
      next_s.rx_ctrl = eng.rx_ctrl;
      next_s.last_poll_final = eng.rx_pf;
    end
    if (eng.input_load) begin
      next_s.input_code = eng.input_code;
    end
    if (eng.frmr_load) begin
      next_s.frmr_data = eng.frmr_data;
    end
    next_s.new_frame_ok = next_s.ctrl.tx_permit;
    next_s.force_dm_all = next_s.ctrl.forced_disconnect ||
                          !next_s.ctrl.disconnected_response_mode;
    next_s.idle_ones = next_s.ctrl.forced_disconnect;
    next_s.answer_per_protocol = !next_s.ctrl.forced_disconnect &&
                                 next_s.ctrl.disconnected_response_mode;
    next_s.rd_data = XLR_RD_NONE;
    if (rd_hit) begin
      case (addr)
        XLR_OFF_CTRL: next_s.rd_data = s.ctrl;
        XLR_OFF_SR0: next_s.rd_data = {s.host_buffers_pending_n,
          s.connected_flag, s.info_transfer_flag, s.state_code};
        XLR_OFF_SR1: next_s.rd_data = {1'b0, s.phys_request_n,
          s.rx_seq_var, s.tx_seq_var};
        XLR_OFF_SR2: next_s.rd_data = {s.acks_done_n, s.prev_next_ack,
          1'b0, s.next_ack_expected};
        XLR_OFF_SR3: next_s.rd_data = s.rx_ctrl;
        XLR_OFF_SR4: next_s.rd_data = {2'b00, s.last_poll_final,
          s.input_code};
        XLR_OFF_SR5: next_s.rd_data = s.frmr_data[7:0];
        XLR_OFF_SR6: next_s.rd_data = s.frmr_data[15:8];
        XLR_OFF_SR7: next_s.rd_data = s.frmr_data[23:16];
        default: next_s.rd_data = XLR_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      // Reset leaves link forced down, verdict and set-up bits clear
      s.ctrl <= xlr_ctrl_s'(XLR_CTRL_RST);
      s.host_buffers_pending_n <= 1'b1;
      s.input_code <= XLR_IN_AFTER_RST;
      s.force_dm_all <= 1'b1;
      s.idle_ones <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rd_data;
  assign ctrl = s.ctrl;
  assign new_frame_ok = s.new_frame_ok;
  assign force_dm_all = s.force_dm_all;
  assign idle_ones = s.idle_ones;
  assign answer_per_protocol = s.answer_per_protocol;

  property p_txp_hpe;
    @(posedge clk) disable iff (rst) eng.tx_hpe |=> !s.ctrl.tx_permit;
  endproperty
  a_txp_hpe: assert property (p_txp_hpe) else $error("tx_permit kept");
  property p_rxb_clr;
    @(posedge clk) disable iff (rst)
      (eng.rx_hpe || eng.rx_overrun) |=> !s.ctrl.rx_buffers_available;
  endproperty
  a_rxb_clr: assert property (p_rxb_clr) else $error("rx buf kept");
  property p_newf;
    @(posedge clk) disable iff (rst) new_frame_ok == s.ctrl.tx_permit;
  endproperty
  a_newf: assert property (p_newf) else $error("new frame gate");
  property p_fdisc;
    @(posedge clk) disable iff (rst)
      s.ctrl.forced_disconnect |-> (idle_ones && force_dm_all);
  endproperty
  a_fdisc: assert property (p_fdisc) else $error("forced disc");
  property p_dmode;
    @(posedge clk) disable iff (rst)
      !s.ctrl.disconnected_response_mode |-> force_dm_all;
  endproperty
  a_dmode: assert property (p_dmode) else $error("dm mode");
  property p_info;
    @(posedge clk) disable iff (rst)
      !rst |=> s.info_transfer_flag == xlr_info($past(eng.state_code));
  endproperty
  a_info: assert property (p_info) else $error("info flag");
  property p_conn;
    @(posedge clk) disable iff (rst) s.info_transfer_flag |-> s.connected_flag;
  endproperty
  a_conn: assert property (p_conn) else $error("connected flag");
  property p_hdn;
    @(posedge clk) disable iff (rst)
      (wr_hit && addr == XLR_OFF_SR0 && !eng.link_reinit)
        |=> !s.host_buffers_pending_n;
  endproperty
  a_hdn: assert property (p_hdn) else $error("pending not cleared");
  property p_lna;
    @(posedge clk) disable iff (rst)
      eng.next_ack_load |=> s.prev_next_ack == $past(s.next_ack_expected);
  endproperty
  a_lna: assert property (p_lna) else $error("prev ack");
  property p_sr2z;
    @(posedge clk) disable iff (rst)
      (rd_hit && addr == XLR_OFF_SR2) |=> !rdata[3];
  endproperty
  a_sr2z: assert property (p_sr2z) else $error("sr2 bit3");
  property p_frmr;
    @(posedge clk) disable iff (rst)
      eng.frmr_load |=> s.frmr_data == $past(eng.frmr_data);
  endproperty
  a_frmr: assert property (p_frmr) else $error("frmr capture");
  // Command writes: each field takes its written bit next cycle unless a
  // fault clear lands in the same cycle, in which case the clear wins
  sequence s_ctrl_wr;
    !rst && wr_hit && addr == XLR_OFF_CTRL;
  endsequence
  sequence s_rd(logic [4:0] a);
    !rst && rd_hit && addr == a;
  endsequence
  sequence s_load(logic ld);
    !rst && ld;
  endsequence
  property p_txp_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr ##0 !eng.tx_hpe
        |=> s.ctrl.tx_permit == $past(wdata[XLR_B_TXP]);
  endproperty
  a_txp_wr: assert property (p_txp_wr) else $error("tx_permit write");
  property p_newf_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr ##0 !eng.tx_hpe
        |=> new_frame_ok == $past(wdata[XLR_B_TXP]);
  endproperty
  a_newf_wr: assert property (p_newf_wr) else $error("gate write");
  property p_fdisc_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr |=> s.ctrl.forced_disconnect == $past(wdata[XLR_B_FDISC]);
  endproperty
  a_fdisc_wr: assert property (p_fdisc_wr) else $error("disc write");
  property p_rxb_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr ##0 !(eng.rx_hpe || eng.rx_overrun)
        |=> s.ctrl.rx_buffers_available == $past(wdata[XLR_B_RXBUF]);
  endproperty
  a_rxb_wr: assert property (p_rxb_wr) else $error("rx buf write");
  property p_act_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr |=> s.ctrl.active_setup == $past(wdata[XLR_B_ACT]);
  endproperty
  a_act_wr: assert property (p_act_wr) else $error("setup write");
  property p_pwi_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr |=> s.ctrl.password_initiate == $past(wdata[XLR_B_PWI]);
  endproperty
  a_pwi_wr: assert property (p_pwi_wr) else $error("pw start write");
  property p_pwv_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr |=> {s.ctrl.password_verdict_hi, s.ctrl.password_verdict_lo}
        == $past(wdata[XLR_B_PWHI:XLR_B_PWLO]);
  endproperty
  a_pwv_wr: assert property (p_pwv_wr) else $error("verdict write");
  property p_dmode_wr;
    @(posedge clk) disable iff (rst)
      s_ctrl_wr
        |=> s.ctrl.disconnected_response_mode == $past(wdata[XLR_B_DMODE]);
  endproperty
  a_dmode_wr: assert property (p_dmode_wr) else $error("mode write");
  // Command bits move only on a host write or a hardware clear
  property p_ctrl_keep;
    @(posedge clk) disable iff (rst)
      !rst && !(wr_hit && addr == XLR_OFF_CTRL) && !eng.tx_hpe &&
        !eng.rx_hpe && !eng.rx_overrun |=> $stable(s.ctrl);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("drift");
  property p_ans;
    @(posedge clk) disable iff (rst)
      answer_per_protocol |-> !force_dm_all && !idle_ones;
  endproperty
  a_ans: assert property (p_ans) else $error("answer mode");
  property p_state;
    @(posedge clk) disable iff (rst)
      !rst |=> s.state_code == $past(eng.state_code);
  endproperty
  a_state: assert property (p_state) else $error("state code");
  property p_sr0_rd;
    @(posedge clk) disable iff (rst)
      s_rd(XLR_OFF_SR0) |=> rdata == {$past(s.host_buffers_pending_n),
        $past(s.connected_flag), $past(s.info_transfer_flag),
        $past(s.state_code)};
  endproperty
  a_sr0_rd: assert property (p_sr0_rd) else $error("sr0 read");
  property p_conn_code;
    @(posedge clk) disable iff (rst)
      !rst |=> s.connected_flag == xlr_connected($past(eng.state_code));
  endproperty
  a_conn_code: assert property (p_conn_code) else $error("link up");
  property p_hdn_set;
    @(posedge clk) disable iff (rst)
      s_load(eng.link_reinit) |=> s.host_buffers_pending_n;
  endproperty
  a_hdn_set: assert property (p_hdn_set) else $error("pending set");
  property p_hdn_keep;
    @(posedge clk) disable iff (rst)
      !rst && !s.host_buffers_pending_n && !eng.link_reinit
        |=> !s.host_buffers_pending_n;
  endproperty
  a_hdn_keep: assert property (p_hdn_keep) else $error("pend");
  property p_seq;
    @(posedge clk) disable iff (rst)
      !rst |=> s.tx_seq_var == $past(eng.tx_seq_var) &&
        s.rx_seq_var == $past(eng.rx_seq_var);
  endproperty
  a_seq: assert property (p_seq) else $error("seq vars");
  property p_sr1_rd;
    @(posedge clk) disable iff (rst)
      s_rd(XLR_OFF_SR1) |=> rdata[6:0] == {$past(s.phys_request_n),
        $past(s.rx_seq_var), $past(s.tx_seq_var)};
  endproperty
  a_sr1_rd: assert property (p_sr1_rd) else $error("sr1 read");
  property p_na_load;
    @(posedge clk) disable iff (rst)
      s_load(eng.next_ack_load)
        |=> s.next_ack_expected == $past(eng.next_ack_expected);
  endproperty
  a_na_load: assert property (p_na_load) else $error("next ack");
  property p_na_keep;
    @(posedge clk) disable iff (rst)
      !rst && !eng.next_ack_load
        |=> $stable(s.next_ack_expected) && $stable(s.prev_next_ack);
  endproperty
  a_na_keep: assert property (p_na_keep) else $error("ack moved");
  property p_ackn;
    @(posedge clk) disable iff (rst)
      !rst |=> s.acks_done_n == $past(eng.acks_busy);
  endproperty
  a_ackn: assert property (p_ackn) else $error("acks done");
  property p_rxctl;
    @(posedge clk) disable iff (rst)
      s_load(eng.rx_frame_ok) |=> s.rx_ctrl == $past(eng.rx_ctrl);
  endproperty
  a_rxctl: assert property (p_rxctl) else $error("rx control");
  property p_rx_keep;
    @(posedge clk) disable iff (rst)
      !rst && !eng.rx_frame_ok
        |=> $stable(s.rx_ctrl) && $stable(s.last_poll_final);
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx");
  property p_input;
    @(posedge clk) disable iff (rst)
      s_load(eng.input_load) |=> s.input_code == $past(eng.input_code);
  endproperty
  a_input: assert property (p_input) else $error("input code");
  property p_pf;
    @(posedge clk) disable iff (rst)
      s_load(eng.rx_frame_ok) |=> s.last_poll_final == $past(eng.rx_pf);
  endproperty
  a_pf: assert property (p_pf) else $error("poll final");
  property p_sr5_rd;
    @(posedge clk) disable iff (rst)
      s_rd(XLR_OFF_SR5) |=> rdata == $past(s.frmr_data[7:0]);
  endproperty
  a_sr5_rd: assert property (p_sr5_rd) else $error("frmr read");
endmodule // xlr_regs

// >>> common/xlr_pkg.sv
// Purpose: Constants and carriers for the link command and status bank
// Assumes: 8-bit host data, register index taken as byte address
// Notes: Protocol engine outside this bank supplies the status values
package xlr_pkg;
  localparam int XLR_AW = 5;
  localparam logic [4:0] XLR_OFF_CTRL = 5'h00;
  localparam logic [4:0] XLR_OFF_SR0 = 5'h01;
  localparam logic [4:0] XLR_OFF_SR1 = 5'h02;
  localparam logic [4:0] XLR_OFF_SR2 = 5'h03;
  localparam logic [4:0] XLR_OFF_SR3 = 5'h04;
  localparam logic [4:0] XLR_OFF_SR4 = 5'h05;
  localparam logic [4:0] XLR_OFF_SR5 = 5'h06;
  localparam logic [4:0] XLR_OFF_SR6 = 5'h07;
  localparam logic [4:0] XLR_OFF_SR7 = 5'h08;
  localparam int XLR_B_TXP = 0;
  localparam int XLR_B_FDISC = 1;
  localparam int XLR_B_RXBUF = 2;
  localparam int XLR_B_ACT = 3;
  localparam int XLR_B_PWI = 4;
  localparam int XLR_B_PWLO = 5;
  localparam int XLR_B_PWHI = 6;
  localparam int XLR_B_DMODE = 7;
  localparam logic [7:0] XLR_CTRL_RST = 8'h82;
  localparam logic [4:0] XLR_ST_INFO = 5'h06;
  localparam logic [4:0] XLR_ST_LINKSETUP = 5'h04;
  localparam logic [4:0] XLR_ST_DISC = 5'h01;
  localparam logic [4:0] XLR_ST_SUPER = 5'h00;
  localparam logic [4:0] XLR_ST_FRMR = 5'h07;
  localparam logic [4:0] XLR_ST_DREQ = 5'h05;
  localparam logic [4:0] XLR_IN_AFTER_RST = 5'h07;
  localparam logic [7:0] XLR_RD_NONE = 8'h00;

  // Status pushed in by the protocol engine
  typedef struct packed {
    logic [4:0] state_code;
    logic [2:0] tx_seq_var;
    logic [2:0] rx_seq_var;
    logic phys_request_n;
    logic [2:0] next_ack_expected;
    logic next_ack_load;
    logic acks_busy;
    logic rx_frame_ok;
    logic [7:0] rx_ctrl;
    logic rx_pf;
    logic input_load;
    logic [4:0] input_code;
    logic frmr_load;
    logic [23:0] frmr_data;
    logic tx_hpe;
    logic rx_hpe;
    logic rx_overrun;
    logic link_reinit;
  } xlr_eng_s;

  // Command bits driven back to the engine
  typedef struct packed {
    logic disconnected_response_mode;
    logic password_verdict_hi;
    logic password_verdict_lo;
    logic password_initiate;
    logic active_setup;
    logic rx_buffers_available;
    logic forced_disconnect;
    logic tx_permit;
  } xlr_ctrl_s;

  typedef struct packed {
    xlr_ctrl_s ctrl;
    logic [4:0] state_code;
    logic info_transfer_flag;
    logic connected_flag;
    logic host_buffers_pending_n;
    logic [2:0] tx_seq_var;
    logic [2:0] rx_seq_var;
    logic phys_request_n;
    logic [2:0] next_ack_expected;
    logic [2:0] prev_next_ack;
    logic acks_done_n;
    logic [7:0] rx_ctrl;
    logic [4:0] input_code;
    logic last_poll_final;
    logic [23:0] frmr_data;
    logic [7:0] rd_data;
    logic new_frame_ok;
    logic force_dm_all;
    logic idle_ones;
    logic answer_per_protocol;
  } xlr_state_s;
endpackage

// >>> test/xlr_eng_model.sv
// Purpose: Protocol engine stand-in feeding status into the register bank
// Assumes: Levels hold between pushes; event strobes last one cycle
// Notes: Values change just after a rising edge, by non-blocking assignment
`timescale 1ns/1ns
module xlr_eng_model
  import xlr_pkg::*;
(
  input wire logic clk,
  output xlr_eng_s eng
);
  initial begin
    eng = '0;
  end

  // Strobes drop after one cycle so a held level is never taken twice
  task automatic push(input xlr_eng_s v);
    xlr_eng_s s;
    s = v;
    s.next_ack_load = 1'b0;
    s.rx_frame_ok = 1'b0;
    s.input_load = 1'b0;
    s.frmr_load = 1'b0;
    s.tx_hpe = 1'b0;
    s.rx_hpe = 1'b0;
    s.rx_overrun = 1'b0;
    s.link_reinit = 1'b0;
    @(posedge clk);
    eng <= v;
    @(posedge clk);
    eng <= s;
    @(posedge clk);
  endtask
endmodule // xlr_eng_model

// >>> test/testbench.sv
// Purpose: Register-level checks of the link command and status bank
// Assumes: Engine status comes from the stand-in model
// Notes: Reads are sampled just after the edge that takes them
`timescale 1ns/1ns
module testbench;
  import xlr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  xlr_eng_s eng;
  xlr_eng_s ev;
  xlr_ctrl_s ctrl;
  logic new_frame_ok, force_dm_all, idle_ones, answer_per_protocol;
  logic [7:0] d;
  int fail_count = 0;
  int n_tests = 0;
  logic [4:0] st [8] = '{5'h00, 5'h01, 5'h04, 5'h07, 5'h05, 5'h06, 5'h11,
                         5'h0a};
  logic [1:0] fl [8] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b10, 2'b11, 2'b11,
                         2'b11};

  always #25 clk = ~clk;

  xlr_eng_model eng_u (.clk(clk), .eng(eng));
  xlr_regs dut_u (.clk(clk), .rst(rst), .cs_n(cs_n), .wr(wr), .rd(rd),
    .addr(addr), .wdata(wdata), .eng(eng), .rdata(rdata), .ctrl(ctrl),
    .new_frame_ok(new_frame_ok), .force_dm_all(force_dm_all),
    .idle_ones(idle_ones), .answer_per_protocol(answer_per_protocol));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    cs_n <= 1'b1;
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    cs_n <= 1'b1;
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    rd_reg(a, d);
    chk8(d, exp);
  endtask

  // Outputs seen by the engine: tx gate, DM to all, ones idle, per protocol
  task automatic out_chk(input logic [3:0] exp);
    chk8({4'h0, new_frame_ok, force_dm_all, idle_ones, answer_per_protocol},
         {4'h0, exp});
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end

  initial begin
    ev = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    out_chk(4'b0110);
    rd_chk(XLR_OFF_CTRL, XLR_CTRL_RST);
    rd_chk(XLR_OFF_SR0, 8'h80);
    rd_chk(XLR_OFF_SR4, {3'b000, XLR_IN_AFTER_RST});
    wr_reg(XLR_OFF_CTRL, 8'h01);
    out_chk(4'b1100);
    wr_reg(XLR_OFF_CTRL, 8'h8d);
    out_chk(4'b1001);
    wr_reg(XLR_OFF_CTRL, 8'h05);
    out_chk(4'b1100);
    for (int i = 0; i < 4; i++) begin
      d = {1'b1, 3'b010 + 3'(i), 4'b0101};
      wr_reg(XLR_OFF_CTRL, d);
      chk8(ctrl, d);
      rd_chk(XLR_OFF_CTRL, d);
    end
    // Each fault clears only its own permission bit
    for (int i = 0; i < 3; i++) begin
      wr_reg(XLR_OFF_CTRL, 8'h05);
      ev.tx_hpe = (i == 0);
      ev.rx_hpe = (i == 1);
      ev.rx_overrun = (i == 2);
      eng_u.push(ev);
      rd_chk(XLR_OFF_CTRL, (i == 0) ? 8'h04 : 8'h01);
    end
    ev = '0;
    ev.link_reinit = 1'b1;
    eng_u.push(ev);
    wr_reg(XLR_OFF_SR0, 8'h7f);
    for (int i = 0; i < 8; i++) begin
      ev = '0;
      ev.state_code = st[i];
      eng_u.push(ev);
      rd_chk(XLR_OFF_SR0, {1'b0, fl[i], st[i]});
    end
    ev.link_reinit = 1'b1;
    eng_u.push(ev);
    rd_chk(XLR_OFF_SR0, {3'b111, st[7]});
    wr_reg(XLR_OFF_SR0, 8'h00);
    rd_chk(XLR_OFF_SR0, {3'b011, st[7]});
    ev = '0;
    ev.tx_seq_var = 3'd5;
    ev.rx_seq_var = 3'd3;
    ev.phys_request_n = 1'b1;
    eng_u.push(ev);
    wr_reg(XLR_OFF_SR1, 8'h00);
    rd_chk(XLR_OFF_SR1, 8'h5d);
    ev.next_ack_expected = 3'd2;
    ev.next_ack_load = 1'b1;
    eng_u.push(ev);
    ev.next_ack_expected = 3'd6;
    ev.acks_busy = 1'b1;
    eng_u.push(ev);
    rd_chk(XLR_OFF_SR2, 8'ha6);
    ev.acks_busy = 1'b0;
    ev.next_ack_load = 1'b0;
    ev.next_ack_expected = 3'd1;
    eng_u.push(ev);
    rd_chk(XLR_OFF_SR2, 8'h26);
    ev.rx_frame_ok = 1'b1;
    ev.rx_ctrl = 8'ha5;
    ev.rx_pf = 1'b1;
    ev.input_load = 1'b1;
    ev.input_code = 5'd26;
    ev.frmr_load = 1'b1;
    ev.frmr_data = 24'h332211;
    eng_u.push(ev);
    rd_chk(XLR_OFF_SR3, 8'ha5);
    rd_chk(XLR_OFF_SR4, 8'h3a);
    for (int i = 0; i < 3; i++) begin
      rd_chk(XLR_OFF_SR5 + 5'(i), 8'h11 * 8'(i + 1));
    end
    rd_chk(5'h1f, XLR_RD_NONE);
    // Mid-run reset must restore command bits, pending flag and input code
    wr_reg(XLR_OFF_CTRL, 8'h7d);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    out_chk(4'b0110);
    rd_chk(XLR_OFF_CTRL, XLR_CTRL_RST);
    rd_chk(XLR_OFF_SR0, 8'h80);
    rd_chk(XLR_OFF_SR4, {3'b000, XLR_IN_AFTER_RST});
    report_and_stop;
  end
endmodule // testbench
